//--- verilog/rsb_map.svh
/*
 Constant map of the receive status and self-test checker: status codes,
 substitute characters, mode codes and timing counts.
 Assumes it is included by bare name by the package users.
*/
`ifndef RSB_MAP_SVH
`define RSB_MAP_SVH

// --------------------------------------------------------------------------
// Independent-mode status codes
// --------------------------------------------------------------------------
`define RSB_IND_DATA      3'h0
`define RSB_IND_SPECIAL   3'h1
`define RSB_IND_EBUF      3'h2
`define RSB_IND_FRAME     3'h3
`define RSB_IND_VIOL      3'h4
`define RSB_IND_NOLOCK    3'h5
`define RSB_IND_DISP      3'h6
`define RSB_IND_INVALID   3'h7

// --------------------------------------------------------------------------
// Self-test status codes
// --------------------------------------------------------------------------
`define RSB_ST_DATA_OK    3'h0
`define RSB_ST_CMD_OK     3'h1
`define RSB_ST_LAST_GOOD  3'h2
`define RSB_ST_RESERVED   3'h3
`define RSB_ST_LAST_BAD   3'h4
`define RSB_ST_START      3'h5
`define RSB_ST_ERROR      3'h6
`define RSB_ST_WAIT       3'h7

// --------------------------------------------------------------------------
// Substitute characters, mode codes, pattern and timing constants
// --------------------------------------------------------------------------
`define RSB_CHAR_C0_7     8'he0
`define RSB_CHAR_C4_7     8'he4
`define RSB_CHAR_D0_0     8'h00
`define RSB_MODE_LL       2'h0
`define RSB_MODE_LH       2'h1
`define RSB_LFSR_SEED     8'h01
`define RSB_EXCESS_LIMIT  16
`define RSB_RECENTER_CHARS 4'h9

`endif

//--- verilog/rsb_pkg.sv
/*
 Types shared by the receive status and self-test checker modules.
 Assumes the map header sits in the include path.
*/
package rsb_pkg;
   // Compare state machine states
   typedef enum logic [1:0] {
      RSB_S_START,
      RSB_S_WAIT,
      RSB_S_RUN
   } rsb_state_t;

   // One character status code
   typedef logic [2:0] rsb_status_t;
endpackage

//--- verilog/rsb_bal_if.sv
/*
 Interface between the compare machine and the error balance counter.
 Assumes both ends run on the same clock.
*/
interface rsb_bal_if;
   logic match;
   logic error;
   logic clear;
   logic excess;

   modport src (output match, output error, output clear, input excess);
   modport bal (input match, input error, input clear, output excess);
endinterface

//--- verilog/rsb_balance.sv
/*
 Error-minus-match balance counter for the self-test compare machine.
 Assumes one-cycle match and error pulses on the checker clock.
*/
`include "rsb_map.svh"
module rsb_balance
   import rsb_pkg::*;
#(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic arst_n,
   // Pulses from the compare machine
   rsb_bal_if.bal    bus
);
   localparam logic signed [W-1:0] LIMIT = W'(`RSB_EXCESS_LIMIT);
   localparam logic signed [W-1:0] MAXV  = {1'b0, {(W-1){1'b1}}};
   localparam logic signed [W-1:0] MINV  = {1'b1, {(W-1){1'b0}}};

   if (W < 6) begin : g_chk
      $error("rsb_balance: W too small to hold the excess limit");
   end

   logic signed [W-1:0] diff_reg;

   // Saturating difference; saturation keeps a long good run from wrapping
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         diff_reg <= '0;
      end else if (bus.clear) begin
         diff_reg <= '0;
      end else if (bus.error && !bus.match && diff_reg != MAXV) begin
         diff_reg <= diff_reg + W'(1);
      end else if (bus.match && !bus.error && diff_reg != MINV) begin
         diff_reg <= diff_reg - W'(1);
      end
   end

   // More than the limit, strictly
   assign bus.excess = (diff_reg > LIMIT);
endmodule

//--- verilog/rsb_checker.sv
/*
 Per-channel receive character status encoder with self-test compare
 machine. Assumes decoder inputs arrive on clk with one strobe per
 character; lock and configuration pins are asynchronous and synchronised.
*/
`include "rsb_map.svh"
module rsb_checker
   import rsb_pkg::*;
#(
   parameter int SEQ_LEN = 255,
   parameter int IDX_W   = 8,
   parameter int BAL_W   = 8
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        arst_n,
   // Asynchronous configuration and PLL pins
   input  wire logic [1:0]  rx_channel_mode_select,
   input  wire logic        rx_selftest_en,
   input  wire logic        rx_clock_source_select,
   input  wire logic        rx_pll_locked,
   // Decoder results, one strobe per character
   input  wire logic        dec_valid,
   input  wire logic [7:0]  dec_data,
   input  wire logic        dec_special,
   input  wire logic        dec_violation,
   input  wire logic        dec_disp_error,
   input  wire logic        framing_match,
   input  wire logic        ebuf_error,
   // Parallel receive output
   output logic             rx_out_valid,
   output logic [7:0]       rx_out_data,
   output rsb_status_t      rx_char_status,
   output logic             rx_clock_source_mid
);
   // -----------------------------------------------------------------------
   // Parameter checks
   // -----------------------------------------------------------------------
   if (SEQ_LEN < 2 || SEQ_LEN > (1 << IDX_W)) begin : g_chk
      $error("rsb_checker: SEQ_LEN does not fit IDX_W or is below 2");
   end

   // -----------------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------------
   localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(SEQ_LEN - 1);

   logic [4:0]       pin_meta_reg;
   logic [4:0]       pin_sync_reg;
   logic             lock_sync;
   logic             mode_indep;
   logic             selftest_on;
   rsb_state_t       state_reg;
   rsb_state_t       state_next;
   logic [7:0]       lfsr_reg;
   logic [7:0]       lfsr_next;
   logic [IDX_W-1:0] idx_reg;
   logic [IDX_W-1:0] idx_next;
   logic [3:0]       hold_reg;
   logic             fault_hold;
   logic             exp_special;
   logic             char_match;
   rsb_status_t      ind_status;
   logic [7:0]       ind_data;
   rsb_status_t      st_status;
   logic             st_match;
   logic             st_error;
   logic             out_selftest_reg;
   logic             out_selftest_next;

   rsb_bal_if bal ();

   // -----------------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------------
   // Two flops on every pin; only the second flop is read
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_meta_reg <= 5'h00;
         pin_sync_reg <= 5'h00;
      end else begin
         pin_meta_reg <= {rx_pll_locked, rx_clock_source_select, rx_selftest_en,
                          rx_channel_mode_select};
         pin_sync_reg <= pin_meta_reg;
      end
   end

   assign lock_sync   = pin_sync_reg[4];
   assign selftest_on = pin_sync_reg[2];
   assign mode_indep  = (pin_sync_reg[1:0] == `RSB_MODE_LL) ||
                        (pin_sync_reg[1:0] == `RSB_MODE_LH);

   // -----------------------------------------------------------------------
   // Independent-mode encoder
   // -----------------------------------------------------------------------
   // Priority chain: lock, buffer, violation, framing, disparity, special; code 111 is never produced
   always_comb begin
      ind_data = dec_data;
      if (!lock_sync) begin
         ind_status = `RSB_IND_NOLOCK;
      end else if (ebuf_error) begin
         ind_status = `RSB_IND_EBUF;
      end else if (dec_violation) begin
         ind_status = `RSB_IND_VIOL;
         ind_data   = `RSB_CHAR_C0_7;
      end else if (framing_match) begin
         ind_status = `RSB_IND_FRAME;
      end else if (dec_disp_error) begin
         ind_status = `RSB_IND_DISP;
         ind_data   = `RSB_CHAR_C4_7;
      end else if (dec_special) begin
         ind_status = `RSB_IND_SPECIAL;
      end else begin
         ind_status = `RSB_IND_DATA;
      end
   end

   // -----------------------------------------------------------------------
   // Expected pattern
   // -----------------------------------------------------------------------
   // Command characters are taken where the top three pattern bits are set
   assign exp_special = (lfsr_reg[7:5] == 3'h7);
   assign char_match  = !dec_violation && !dec_disp_error &&
                        (dec_data == lfsr_reg) && (dec_special == exp_special);
   assign fault_hold  = ebuf_error || (hold_reg != 4'h0);

   // -----------------------------------------------------------------------
   // Self-test compare machine, next state
   // -----------------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      lfsr_next  = lfsr_reg;
      idx_next   = idx_reg;
      st_status  = `RSB_ST_START;
      st_match   = 1'b0;
      st_error   = 1'b0;
      if (!lock_sync || !selftest_on) begin
         state_next = RSB_S_START;
      end else if (fault_hold) begin
         state_next = RSB_S_START;
      end else if (dec_valid) begin
         unique case (state_reg)
            RSB_S_START: begin
               state_next = RSB_S_WAIT;
            end
            RSB_S_WAIT: begin
               st_status = `RSB_ST_WAIT;
               if (!dec_special && !dec_violation && dec_data == `RSB_CHAR_D0_0) begin
                  st_status  = `RSB_ST_DATA_OK;
                  state_next = RSB_S_RUN;
                  lfsr_next  = `RSB_LFSR_SEED;
                  idx_next   = IDX_W'(1);
               end
            end
            RSB_S_RUN: begin
               st_match  = char_match;
               st_error  = !char_match;
               lfsr_next = {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^
                            lfsr_reg[3]};
               idx_next  = idx_reg + IDX_W'(1);
               if (idx_reg == LAST_IDX) begin
                  st_status  = char_match ? `RSB_ST_LAST_GOOD : `RSB_ST_LAST_BAD;
                  state_next = RSB_S_WAIT;
               end else if (!char_match) begin
                  st_status = `RSB_ST_ERROR;
               end else if (exp_special) begin
                  st_status = `RSB_ST_CMD_OK;
               end else begin
                  st_status = `RSB_ST_DATA_OK;
               end
               if (bal.excess) begin
                  state_next = RSB_S_WAIT;
               end
            end
         endcase
      end
   end

   // Balance counter is cleared whenever no sequence is being compared
   assign bal.match = st_match;
   assign bal.error = st_error;
   assign bal.clear = (state_reg != RSB_S_RUN);

   rsb_balance #(
      .W      (BAL_W)
   ) u_balance (
      .clk    (clk),
      .arst_n (arst_n),
      .bus    (bal)
   );

   // -----------------------------------------------------------------------
   // Compare machine state
   // -----------------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= RSB_S_START;
         lfsr_reg  <= `RSB_LFSR_SEED;
         idx_reg   <= '0;
      end else begin
         state_reg <= state_next;
         lfsr_reg  <= lfsr_next;
         idx_reg   <= idx_next;
      end
   end

   // Recentre hold counts characters, not clocks, since the buffer refills per character
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hold_reg <= 4'h0;
      end else if (ebuf_error) begin
         hold_reg <= `RSB_RECENTER_CHARS;
      end else if (dec_valid && hold_reg != 4'h0) begin
         hold_reg <= hold_reg - 4'h1;
      end
   end

   // -----------------------------------------------------------------------
   // Output registers
   // -----------------------------------------------------------------------
   assign out_selftest_next = selftest_on;

   // Status follows the character strobe; lock loss is shown even between strobes
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_out_valid     <= 1'b0;
         rx_out_data      <= 8'h00;
         rx_char_status   <= `RSB_ST_START;
         out_selftest_reg <= 1'b0;
      end else begin
         rx_out_valid <= dec_valid;
         if (dec_valid) begin
            out_selftest_reg <= out_selftest_next;
            rx_out_data      <= out_selftest_next ? dec_data : ind_data;
         end
         if (out_selftest_next && (!lock_sync || fault_hold)) begin
            rx_char_status <= `RSB_ST_START;
         end else if (out_selftest_next && dec_valid) begin
            rx_char_status <= st_status;
         end else if (!out_selftest_next && (dec_valid || !lock_sync)) begin
            rx_char_status <= mode_indep ? ind_status : `RSB_IND_NOLOCK;
         end
      end
   end

   // Selection is mirrored out so the link partner can be configured alike
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_clock_source_mid <= 1'b0;
      end else begin
         rx_clock_source_mid <= pin_sync_reg[3];
      end
   end

   // -----------------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------------
   logic ind_ok;
   assign ind_ok = dec_valid && !selftest_on && mode_indep && lock_sync;

   property p_ind_data;
      @(posedge clk) disable iff (!arst_n)
      ind_ok && !ebuf_error && !dec_violation && !framing_match && !dec_disp_error &&
      !dec_special |=> rx_char_status == 3'h0 && rx_out_data == $past(dec_data);
   endproperty
   a_ind_data: assert property (p_ind_data) else $error("data status wrong");

   property p_ind_special;
      @(posedge clk) disable iff (!arst_n)
      ind_ok && !ebuf_error && !dec_violation && !framing_match && !dec_disp_error &&
      dec_special |=> rx_char_status == 3'h1;
   endproperty
   a_ind_special: assert property (p_ind_special) else $error("special status wrong");

   property p_ind_ebuf;
      @(posedge clk) disable iff (!arst_n)
      ind_ok && ebuf_error |=> rx_char_status == 3'h2;
   endproperty
   a_ind_ebuf: assert property (p_ind_ebuf) else $error("buffer status wrong");

   property p_ind_frame;
      @(posedge clk) disable iff (!arst_n)
      ind_ok && !ebuf_error && !dec_violation && framing_match
      |=> rx_char_status == 3'h3 && rx_out_data == $past(dec_data);
   endproperty
   a_ind_frame: assert property (p_ind_frame) else $error("framing status wrong");

   property p_ind_viol;
      @(posedge clk) disable iff (!arst_n)
      ind_ok && !ebuf_error && dec_violation |=> rx_char_status == 3'h4 &&
      rx_out_data == 8'he0;
   endproperty
   a_ind_viol: assert property (p_ind_viol) else $error("violation status wrong");

   property p_ind_lock;
      @(posedge clk) disable iff (!arst_n)
      !selftest_on && !lock_sync |=> rx_char_status == 3'h5;
   endproperty
   a_ind_lock: assert property (p_ind_lock) else $error("lock status wrong");

   property p_ind_disp;
      @(posedge clk) disable iff (!arst_n)
      ind_ok && !ebuf_error && !dec_violation && !framing_match && dec_disp_error
      |=> rx_char_status == 3'h6 && rx_out_data == 8'he4;
   endproperty
   a_ind_disp: assert property (p_ind_disp) else $error("disparity status wrong");

   property p_no_invalid;
      @(posedge clk) disable iff (!arst_n)
      rx_out_valid && !out_selftest_reg |-> rx_char_status != 3'h7;
   endproperty
   a_no_invalid: assert property (p_no_invalid) else $error("code 111 emitted");

   property p_no_reserved;
      @(posedge clk) disable iff (!arst_n)
      out_selftest_reg |-> rx_char_status != 3'h3;
   endproperty
   a_no_reserved: assert property (p_no_reserved) else $error("code 011 emitted");

   property p_lock_start;
      @(posedge clk) disable iff (!arst_n)
      !lock_sync |=> state_reg == RSB_S_START;
   endproperty
   a_lock_start: assert property (p_lock_start) else $error("lock loss kept state");

   property p_recenter;
      @(posedge clk) disable iff (!arst_n)
      ebuf_error |=> hold_reg == 4'h9 && state_reg == RSB_S_START;
   endproperty
   a_recenter: assert property (p_recenter) else $error("recentre hold missing");

   property p_excess_wait;
      @(posedge clk) disable iff (!arst_n)
      state_reg == RSB_S_RUN && bal.excess && dec_valid && lock_sync && !fault_hold &&
      selftest_on |=> state_reg == RSB_S_WAIT;
   endproperty
   a_excess_wait: assert property (p_excess_wait) else $error("excess did not wait");

   property p_wait_code;
      @(posedge clk) disable iff (!arst_n)
      state_reg == RSB_S_WAIT && dec_valid && lock_sync && !fault_hold && selftest_on &&
      (dec_special || dec_data != 8'h00) |=> rx_char_status == 3'h7;
   endproperty
   a_wait_code: assert property (p_wait_code) else $error("wait code wrong");

   property p_mismatch;
      @(posedge clk) disable iff (!arst_n)
      state_reg == RSB_S_RUN && dec_valid && lock_sync && !fault_hold && selftest_on &&
      !char_match && idx_reg != LAST_IDX |=> rx_char_status == 3'h6;
   endproperty
   a_mismatch: assert property (p_mismatch) else $error("mismatch code wrong");
endmodule

//--- tb/rsb_host_model.sv
/*
 Host model on the parallel receive bus: latches every presented
 character and counts the valid pulses.
 Assumes it shares the checker clock and reset.
*/
module rsb_host_model
   import rsb_pkg::*;
(
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         arst_n,
   // Parallel receive bus
   input  wire logic         rx_out_valid,
   input  wire logic [7:0]   rx_out_data,
   input  wire rsb_status_t  rx_char_status,
   // Captured view
   output logic [7:0]        host_data_reg,
   output rsb_status_t       host_status_reg,
   output int                host_count
);
   timeunit 1ns;
   timeprecision 1ps;

   // A stuck valid would inflate the count, so the bench can catch it
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         host_data_reg   <= 8'h00;
         host_status_reg <= 3'h0;
         host_count      <= 0;
      end else if (rx_out_valid) begin
         host_data_reg   <= rx_out_data;
         host_status_reg <= rx_char_status;
         host_count      <= host_count + 1;
      end
   end
endmodule

//--- tb/rsb_checker_bench.sv
/*
 Self-checking bench of the receive status encoder and self-test machine.
 Assumes the design map header and package; drives decoder results.
*/
`include "rsb_map.svh"
module rsb_checker_bench
   import rsb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SEQ = 32;  // Short sequence keeps the run brief

   logic clk, arst_n, st_en, csel, lock, dv, sp, vi, di, fr, eb;
   logic [1:0] mode;
   logic [7:0] dd, od, hd, lf;
   logic ov, omid, e, v, f, d;
   rsb_status_t os, hs;
   int hc, n_errors, compares, n_sent, i;
   int cyc = 0;
   logic [31:0] seed, r;

   rsb_checker #(.SEQ_LEN(SEQ), .IDX_W(8), .BAL_W(8)) dut (
      .clk(clk), .arst_n(arst_n), .rx_channel_mode_select(mode),
      .rx_selftest_en(st_en), .rx_clock_source_select(csel), .rx_pll_locked(lock),
      .dec_valid(dv), .dec_data(dd), .dec_special(sp), .dec_violation(vi),
      .dec_disp_error(di), .framing_match(fr), .ebuf_error(eb), .rx_out_valid(ov),
      .rx_out_data(od), .rx_char_status(os), .rx_clock_source_mid(omid));

   rsb_host_model host (
      .clk(clk), .arst_n(arst_n), .rx_out_valid(ov), .rx_out_data(od),
      .rx_char_status(os), .host_data_reg(hd), .host_status_reg(hs), .host_count(hc));

   // ----------------------------------------------------------------
   // Clock and watchdog
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // The whole run needs well under this many cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors = n_errors + 1;
         summarize();
      end
   end

   // ----------------------------------------------------------------
   // Expectation functions and compare tasks
   // ----------------------------------------------------------------
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function logic [7:0] lfsr_next(input logic [7:0] l);
      return {l[6:0], l[7] ^ l[5] ^ l[4] ^ l[3]};
   endfunction

   // First flag in buffer, violation, framing, disparity, special order wins
   function rsb_status_t ind_status(input logic e1, v1, f1, d1, s1);
      if (e1) return `RSB_IND_EBUF;
      if (v1) return `RSB_IND_VIOL;
      if (f1) return `RSB_IND_FRAME;
      if (d1) return `RSB_IND_DISP;
      if (s1) return `RSB_IND_SPECIAL;
      return `RSB_IND_DATA;
   endfunction

   function logic [7:0] ind_data(input logic v1, f1, d1, input logic [7:0] x);
      if (v1) return `RSB_CHAR_C0_7;
      if (f1) return x;
      if (d1) return `RSB_CHAR_C4_7;
      return x;
   endfunction

   task chk_st(input rsb_status_t exp);
      compares++;
      if (os !== exp) begin
         $display("unexpected status at %0t: got %h expected %h", $time, os, exp);
         n_errors++;
      end
   endtask

   task chk_dat(input logic [7:0] exp);
      compares++;
      if (od !== exp) begin
         $display("unexpected data at %0t: got %h expected %h", $time, od, exp);
         n_errors++;
      end
   endtask

   task chk_bit(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
         n_errors++;
      end
   endtask

   // One character, then the answer one edge later
   task send(input logic [7:0] x, input logic s1, v1, d1, f1, e1);
      @(posedge clk);
      dv <= 1'b1; dd <= x; sp <= s1; vi <= v1; di <= d1; fr <= f1; eb <= e1;
      @(posedge clk);
      dv <= 1'b0; eb <= 1'b0; dd <= ~x;
      n_sent++;
      #1;
      chk_bit(ov, 1'b1);
   endtask

   task wait_edges(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Whole test sequence starting from the wait state
   task run_seq(input logic bad);
      logic s1;
      send(`RSB_CHAR_D0_0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      chk_st(`RSB_ST_DATA_OK);
      lf = `RSB_LFSR_SEED;
      for (int k = 1; k < SEQ; k++) begin
         s1 = (lf[7:5] == 3'b111);
         send(lf, s1, bad && k == SEQ - 1, 1'b0, 1'b0, 1'b0);
         chk_dat(lf);
         if (k == SEQ - 1)
            chk_st(bad ? `RSB_ST_LAST_BAD : `RSB_ST_LAST_GOOD);
         else if (s1)
            chk_st(`RSB_ST_CMD_OK);
         else
            chk_st(`RSB_ST_DATA_OK);
         lf = lfsr_next(lf);
      end
   endtask

   task summarize();
      $display("counts: %0d compares, %0d mismatches", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      arst_n = 1'b0; st_en = 1'b0; csel = 1'b1; lock = 1'b0; dv = 1'b0; dd = 8'h00;
      sp = 1'b0; vi = 1'b0; di = 1'b0; fr = 1'b0; eb = 1'b0; mode = `RSB_MODE_LL;
      seed = 32'd96060; n_errors = 0; compares = 0; n_sent = 0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      #1;
      chk_st(`RSB_ST_START);
      chk_dat(8'h00);
      wait_edges(4);
      chk_st(`RSB_IND_NOLOCK);
      chk_bit(omid, 1'b1);
      $display("test reset done");
      // Independent mode, random flag mixes under both mode codes
      lock <= 1'b1;
      wait_edges(3);
      for (i = 0; i < 60; i++) begin
         if (i == 30) begin
            mode <= `RSB_MODE_LH;
            wait_edges(3);
         end
         r = rnd();
         // No buffer fault late on, so the recentre hold is spent before self-test
         e = r[12] & r[17] & r[18] & (i < 50);
         v = r[9] & r[14];
         d = r[10] & r[15];
         f = r[11] & r[16];
         send(r[7:0], r[8], v, d, f, e);
         chk_st(ind_status(e, v, f, d, r[8]));
         if (!e) chk_dat(ind_data(v, f, d, r[7:0]));
      end
      send(8'h55, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
      chk_dat(`RSB_CHAR_C0_7);
      send(8'h3c, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
      chk_st(`RSB_IND_FRAME);
      chk_dat(8'h3c);
      lock <= 1'b0;
      wait_edges(3);
      chk_st(`RSB_IND_NOLOCK);
      lock <= 1'b1;
      // A mode code outside independent mode reports the lock code
      mode <= 2'h2;
      wait_edges(3);
      send(8'h21, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      chk_st(`RSB_IND_NOLOCK);
      mode <= `RSB_MODE_LL;
      $display("test independent done");
      // Self-test: start, wait, good and bad sequences
      st_en <= 1'b1;
      wait_edges(3);
      send(8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      chk_st(`RSB_ST_START);
      r = rnd();
      send(r[7:0] | 8'h01, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      chk_st(`RSB_ST_WAIT);
      run_seq(1'b0);
      run_seq(1'b1);
      $display("test sequences done");
      // Error balance: one flipped bit then violations
      send(`RSB_CHAR_D0_0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      send(8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      chk_st(`RSB_ST_ERROR);
      for (i = 0; i < 17; i++) begin
         r = rnd();
         send(r[7:0], 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
         chk_st(`RSB_ST_ERROR);
      end
      send(8'h5a, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      chk_st(`RSB_ST_WAIT);
      $display("test balance done");
      // Lock loss in mid-run forces the start state
      send(`RSB_CHAR_D0_0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      lock <= 1'b0;
      wait_edges(4);
      chk_st(`RSB_ST_START);
      lock <= 1'b1;
      wait_edges(3);
      send(8'h5a, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      chk_st(`RSB_ST_START);
      send(8'h5a, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      chk_st(`RSB_ST_WAIT);
      $display("test lock loss done");
      // Buffer fault holds the start code for nine characters
      @(posedge clk);
      eb <= 1'b1;
      @(posedge clk);
      eb <= 1'b0;
      for (i = 0; i < 9; i++) begin
         r = rnd();
         send(r[7:0], 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
         chk_st(`RSB_ST_START);
      end
      send(8'h5a, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      send(8'h5a, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      chk_st(`RSB_ST_WAIT);
      wait_edges(2);
      chk_bit(hc == n_sent, 1'b1);
      chk_bit(hd == od && hs == os, 1'b1);
      $display("test buffer fault done");
      summarize();
   end
endmodule
